//--- rtl/mcx_map.vh
`ifndef MCX_MAP_VH
`define MCX_MAP_VH

// Operation codes on the issue port
`define MCX_OP_LOAD 5'h00
`define MCX_OP_LOCKED_READ 5'h01
`define MCX_OP_READ_SET_ONES 5'h02
`define MCX_OP_MULTI_WORD_READ 5'h03
`define MCX_OP_STORE 5'h04
`define MCX_OP_LOCKED_WRITE 5'h05
`define MCX_OP_MULTI_WORD_WRITE 5'h06
`define MCX_OP_BYTE_EXTRACTION 5'h07
`define MCX_OP_HALFWORD_EXTRACTION 5'h08
`define MCX_OP_SIGNED_HALFWORD_EXTRACTION 5'h09
`define MCX_OP_BYTE_INSERTION 5'h0A
`define MCX_OP_HALFWORD_INSERTION 5'h0B
`define MCX_OP_SPECIAL_REG_READ 5'h0C
`define MCX_OP_SPECIAL_REG_WRITE 5'h0D
`define MCX_OP_SPECIAL_REG_WRITE_IMM 5'h0E
`define MCX_OP_XLAT_ENTRY_READ 5'h0F
`define MCX_OP_XLAT_ENTRY_WRITE 5'h10
`define MCX_OP_IMM16_ZERO_EXT 5'h11
`define MCX_OP_IMM16_UPPER_FILL 5'h12
`define MCX_OP_IMM16_ONES_EXT 5'h13
`define MCX_OP_FLOAT 5'h14
`define MCX_OP_CALL 5'h15
`define MCX_OP_JUMP 5'h16
`define MCX_OP_BRANCH_IF_TRUE 5'h17
`define MCX_OP_BRANCH_IF_FALSE 5'h18
`define MCX_OP_BRANCH_FALSE_DECREMENT 5'h19

// Branch target modes
`define MCX_TM_ABS 2'h0
`define MCX_TM_REL 2'h1
`define MCX_TM_REG 2'h2

// Constants of the data path
`define MCX_WORD_STEP 32'h00000004
`define MCX_SET_ONES 32'hFFFFFFFF
`define MCX_RET_OFS 32'h00000008
`define MCX_DEC_ONE 32'h00000001
`define MCX_TRAP_FP 8'h03
`define MCX_TRAP_PROT 8'h05
`define MCX_SR_USER_BASE 8'h80

`endif

//--- rtl/mcx_field_unit.v
`timescale 1ns/1ps
`include "mcx_map.vh"

module mcx_field_unit (
  input wire [4:0] op,
  input wire [31:0] src_a,
  input wire [31:0] src_b,
  input wire [15:0] imm16,
  input wire [1:0] byte_pointer,
  input wire byte_order,
  output reg [31:0] result
);
  // Lane counted from the least significant byte
  wire [1:0] lane = byte_order ? byte_pointer : ~byte_pointer;
  wire hsel = byte_pointer[1] ^ ~byte_order;
  wire [7:0] a_byte = src_a[8*lane +: 8];
  wire [15:0] a_half = hsel ? src_a[31:16] : src_a[15:0];
  reg [31:0] ins;

  always @* begin
    ins = src_a;
    result = 32'h00000000;
    case (op)
      // [RQ6] byte extraction
      `MCX_OP_BYTE_EXTRACTION: result = {src_b[31:8], a_byte};
      // [RQ7] halfword extraction
      `MCX_OP_HALFWORD_EXTRACTION: result = {src_b[31:16], a_half};
      // [RQ8] signed extraction
      `MCX_OP_SIGNED_HALFWORD_EXTRACTION: result = {{16{a_half[15]}}, a_half};
      // [RQ9] byte insertion
      `MCX_OP_BYTE_INSERTION: begin
        ins[8*lane +: 8] = src_b[7:0];
        result = ins;
      end
      // [RQ10] halfword insertion
      `MCX_OP_HALFWORD_INSERTION: begin
        if (hsel) begin
          result = {src_b[15:0], src_a[15:0]};
        end else begin
          result = {src_a[31:16], src_b[15:0]};
        end
      end
      // [RQ21] zero extended constant
      `MCX_OP_IMM16_ZERO_EXT: result = {16'h0000, imm16};
      // [RQ11] upper half only
      `MCX_OP_IMM16_UPPER_FILL: result = {imm16, src_a[15:0]};
      // [RQ21] ones extended constant
      `MCX_OP_IMM16_ONES_EXT: result = {16'hFFFF, imm16};
      default: result = 32'h00000000;
    endcase
  end
endmodule

//--- rtl/mcx_branch_unit.v
`timescale 1ns/1ps
`include "mcx_map.vh"

module mcx_branch_unit (
  input wire [4:0] op,
  input wire [1:0] tmode,
  input wire [31:0] src_a,
  input wire [31:0] src_b,
  input wire [15:0] imm16,
  input wire [29:0] pc_word,
  output reg taken,
  output reg [31:0] target,
  output wire [31:0] ret_addr,
  output wire [31:0] dec_value
);
  wire [31:0] pc_byte = {pc_word, 2'b00};
  wire [31:0] rel_ofs = {{14{imm16[15]}}, imm16, 2'b00};

  // [RQ16] return address
  assign ret_addr = pc_byte + `MCX_RET_OFS;
  // [RQ18] unconditional decrement
  assign dec_value = src_a - `MCX_DEC_ONE;

  always @* begin
    // [RQ14] target formation
    case (tmode)
      `MCX_TM_ABS: target = {14'h0000, imm16, 2'b00};
      `MCX_TM_REL: target = pc_byte + rel_ofs;
      `MCX_TM_REG: target = src_b;
      default: target = src_b;
    endcase
    // [RQ17] [RQ20] msb boolean test
    case (op)
      `MCX_OP_CALL: taken = 1'b1;
      `MCX_OP_JUMP: taken = 1'b1;
      `MCX_OP_BRANCH_IF_TRUE: taken = src_a[31];
      `MCX_OP_BRANCH_IF_FALSE: taken = ~src_a[31];
      `MCX_OP_BRANCH_FALSE_DECREMENT: taken = ~src_a[31];
      default: taken = 1'b0;
    endcase
  end
endmodule

//--- rtl/mcx_exec.v
// Contract
// [RQ1] Load reads word at second operand
// [RQ2] Locked forms hold bus lock
// [RQ3] Read then write ones, locked
// [RQ4] Multi-word transfers step four bytes
// [RQ5] Store writes first operand to address
// [RQ6] Byte extraction into low byte
// [RQ7] Halfword extraction into low half
// [RQ8] Signed halfword extraction, sign extended
// [RQ9] Byte insertion at pointed position
// [RQ10] Halfword insertion at pointed half
// [RQ11] Upper fill keeps lower half
// [RQ12] Eight-bit immediate replaces register operand
// [RQ13] Floating point always traps
// [RQ14] Absolute, relative or register targets
// [RQ15] Delay instruction always executes
// [RQ16] Calls save address plus eight
// [RQ17] Conditional jumps test boolean sense
// [RQ18] Decrement always, branch if false
// [RQ19] Some moves need supervisor mode
// [RQ20] Boolean is the top bit
// [RQ21] Zero or ones extended constant
// [RQ22] Special and translation moves copy words
`timescale 1ns/1ps
`include "mcx_map.vh"

module mcx_exec #(
  parameter XLAT_AW = 6
) (
  input wire core_clk,
  input wire rstn,
  input wire issue_valid,
  input wire [4:0] issue_op,
  input wire [31:0] issue_a,
  input wire [31:0] issue_b,
  input wire issue_imm_sel,
  input wire [7:0] issue_imm8,
  input wire [15:0] issue_imm16,
  input wire [1:0] issue_tmode,
  input wire [7:0] issue_dest,
  input wire [7:0] issue_a_num,
  input wire [7:0] issue_count,
  input wire [7:0] issue_sr_num,
  input wire [1:0] byte_pointer,
  input wire byte_order,
  input wire [29:0] pc_word,
  input wire supervisor,
  output reg issue_ready_r,
  output reg wb_valid_r,
  output reg [7:0] wb_num_r,
  output reg [31:0] wb_data_r,
  output reg [7:0] rf_rnum_r,
  input wire [31:0] rf_rdata,
  output reg sr_we_r,
  output reg [7:0] special_reg_target_r,
  output reg [31:0] sr_wdata_r,
  input wire [31:0] sr_rdata,
  output reg xlat_we_r,
  output reg [XLAT_AW-1:0] xlat_idx_r,
  output reg [31:0] xlat_wdata_r,
  input wire [31:0] xlat_rdata,
  output reg pc_load_r,
  output reg [31:0] pc_target_r,
  output reg trap_r,
  output reg [7:0] trap_num_r,
  output reg mem_req_r,
  output reg mem_we_r,
  output reg mem_lock_r,
  output reg [31:0] mem_addr_r,
  output reg [31:0] mem_wdata_r,
  input wire mem_ack,
  input wire [31:0] mem_rdata
);
  localparam S_IDLE = 3'h0;
  localparam S_READ = 3'h1;
  localparam S_WRITE = 3'h2;
  localparam S_FETCH = 3'h3;
  localparam S_SPRD = 3'h4;

  reg [2:0] state_r;
  reg [4:0] op_r;
  reg [7:0] dest_r;
  reg [7:0] cnt_r;
  reg [7:0] last_r;
  reg set_pend_r;
  reg pend_r;
  reg [31:0] pend_tgt_r;
  reg sprd_xlat_r;

  wire take = issue_valid & issue_ready_r;
  // [RQ12] immediate operand select
  wire [31:0] opb = issue_imm_sel ? {24'h000000, issue_imm8} : issue_b;
  wire [31:0] field_res;
  wire br_taken;
  wire [31:0] br_target;
  wire [31:0] ret_addr;
  wire [31:0] dec_value;
  wire sr_ok = supervisor | (issue_sr_num >= `MCX_SR_USER_BASE);
  wire more = (cnt_r != last_r);

  mcx_field_unit u_field (
    .op(issue_op),
    .src_a(issue_a),
    .src_b(opb),
    .imm16(issue_imm16),
    .byte_pointer(byte_pointer),
    .byte_order(byte_order),
    .result(field_res)
  );

  mcx_branch_unit u_branch (
    .op(issue_op),
    .tmode(issue_tmode),
    .src_a(issue_a),
    .src_b(opb),
    .imm16(issue_imm16),
    .pc_word(pc_word),
    .taken(br_taken),
    .target(br_target),
    .ret_addr(ret_addr),
    .dec_value(dec_value)
  );

  always @(posedge core_clk) begin
    if (!rstn) begin
      state_r <= S_IDLE;
      op_r <= 5'h00;
      dest_r <= 8'h00;
      cnt_r <= 8'h00;
      last_r <= 8'h00;
      set_pend_r <= 1'b0;
      pend_r <= 1'b0;
      pend_tgt_r <= 32'h00000000;
      sprd_xlat_r <= 1'b0;
      issue_ready_r <= 1'b1;
      wb_valid_r <= 1'b0;
      wb_num_r <= 8'h00;
      wb_data_r <= 32'h00000000;
      rf_rnum_r <= 8'h00;
      sr_we_r <= 1'b0;
      special_reg_target_r <= 8'h00;
      sr_wdata_r <= 32'h00000000;
      xlat_we_r <= 1'b0;
      xlat_idx_r <= {XLAT_AW{1'b0}};
      xlat_wdata_r <= 32'h00000000;
      pc_load_r <= 1'b0;
      pc_target_r <= 32'h00000000;
      trap_r <= 1'b0;
      trap_num_r <= 8'h00;
      mem_req_r <= 1'b0;
      mem_we_r <= 1'b0;
      mem_lock_r <= 1'b0;
      mem_addr_r <= 32'h00000000;
      mem_wdata_r <= 32'h00000000;
    end else begin
      wb_valid_r <= 1'b0;
      sr_we_r <= 1'b0;
      xlat_we_r <= 1'b0;
      pc_load_r <= 1'b0;
      trap_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (take) begin
            op_r <= issue_op;
            dest_r <= issue_dest;
            cnt_r <= 8'h00;
            last_r <= 8'h00;
            // [RQ15] redirect after delay instruction
            if (pend_r) begin
              pc_load_r <= 1'b1;
              pc_target_r <= pend_tgt_r;
              pend_r <= 1'b0;
            end
            case (issue_op)
              `MCX_OP_LOAD, `MCX_OP_LOCKED_READ, `MCX_OP_READ_SET_ONES,
              `MCX_OP_MULTI_WORD_READ: begin
                // [RQ1] issue word read
                mem_req_r <= 1'b1;
                mem_we_r <= 1'b0;
                mem_addr_r <= opb;
                // [RQ2] [RQ3] lock for locked forms
                mem_lock_r <= (issue_op == `MCX_OP_LOCKED_READ) | (issue_op == `MCX_OP_READ_SET_ONES);
                set_pend_r <= (issue_op == `MCX_OP_READ_SET_ONES);
                if (issue_op == `MCX_OP_MULTI_WORD_READ) begin
                  last_r <= issue_count;
                end
                issue_ready_r <= 1'b0;
                state_r <= S_READ;
              end
              `MCX_OP_STORE, `MCX_OP_LOCKED_WRITE: begin
                // [RQ5] write first operand
                mem_req_r <= 1'b1;
                mem_we_r <= 1'b1;
                mem_addr_r <= opb;
                mem_wdata_r <= issue_a;
                // [RQ2] lock during write
                mem_lock_r <= (issue_op == `MCX_OP_LOCKED_WRITE);
                issue_ready_r <= 1'b0;
                state_r <= S_WRITE;
              end
              `MCX_OP_MULTI_WORD_WRITE: begin
                // [RQ4] first register then words
                mem_addr_r <= opb;
                rf_rnum_r <= issue_dest;
                last_r <= issue_count;
                issue_ready_r <= 1'b0;
                state_r <= S_FETCH;
              end
              `MCX_OP_BYTE_EXTRACTION, `MCX_OP_HALFWORD_EXTRACTION,
              `MCX_OP_SIGNED_HALFWORD_EXTRACTION, `MCX_OP_BYTE_INSERTION,
              `MCX_OP_HALFWORD_INSERTION, `MCX_OP_IMM16_ZERO_EXT,
              `MCX_OP_IMM16_UPPER_FILL, `MCX_OP_IMM16_ONES_EXT: begin
                wb_valid_r <= 1'b1;
                wb_num_r <= issue_dest;
                wb_data_r <= field_res;
              end
              `MCX_OP_SPECIAL_REG_READ: begin
                // [RQ19] protected registers
                if (sr_ok) begin
                  special_reg_target_r <= issue_sr_num;
                  sprd_xlat_r <= 1'b0;
                  issue_ready_r <= 1'b0;
                  state_r <= S_SPRD;
                end else begin
                  trap_r <= 1'b1;
                  trap_num_r <= `MCX_TRAP_PROT;
                end
              end
              `MCX_OP_SPECIAL_REG_WRITE, `MCX_OP_SPECIAL_REG_WRITE_IMM: begin
                // [RQ19] protected registers
                if (sr_ok) begin
                  // [RQ22] word copy to special
                  sr_we_r <= 1'b1;
                  special_reg_target_r <= issue_sr_num;
                  if (issue_op == `MCX_OP_SPECIAL_REG_WRITE) begin
                    sr_wdata_r <= opb;
                  end else begin
                    sr_wdata_r <= {16'h0000, issue_imm16};
                  end
                end else begin
                  trap_r <= 1'b1;
                  trap_num_r <= `MCX_TRAP_PROT;
                end
              end
              `MCX_OP_XLAT_ENTRY_READ, `MCX_OP_XLAT_ENTRY_WRITE: begin
                // [RQ19] supervisor only
                if (supervisor) begin
                  // [RQ22] word copy with entry
                  xlat_idx_r <= issue_a[XLAT_AW-1:0];
                  if (issue_op == `MCX_OP_XLAT_ENTRY_WRITE) begin
                    xlat_we_r <= 1'b1;
                    xlat_wdata_r <= opb;
                  end else begin
                    sprd_xlat_r <= 1'b1;
                    issue_ready_r <= 1'b0;
                    state_r <= S_SPRD;
                  end
                end else begin
                  trap_r <= 1'b1;
                  trap_num_r <= `MCX_TRAP_PROT;
                end
              end
              `MCX_OP_FLOAT: begin
                // [RQ13] trap to emulation
                trap_r <= 1'b1;
                trap_num_r <= `MCX_TRAP_FP;
              end
              `MCX_OP_CALL, `MCX_OP_JUMP, `MCX_OP_BRANCH_IF_TRUE,
              `MCX_OP_BRANCH_IF_FALSE, `MCX_OP_BRANCH_FALSE_DECREMENT: begin
                // [RQ15] hold target over delay slot
                pend_r <= br_taken;
                pend_tgt_r <= br_target;
                // [RQ16] save return address
                if (issue_op == `MCX_OP_CALL) begin
                  wb_valid_r <= 1'b1;
                  wb_num_r <= issue_dest;
                  wb_data_r <= ret_addr;
                end
                // [RQ18] write back decrement
                if (issue_op == `MCX_OP_BRANCH_FALSE_DECREMENT) begin
                  wb_valid_r <= 1'b1;
                  wb_num_r <= issue_a_num;
                  wb_data_r <= dec_value;
                end
              end
              default: begin
                wb_valid_r <= 1'b0;
              end
            endcase
          end
        end
        S_READ: begin
          if (mem_ack) begin
            // [RQ1] [RQ4] word to consecutive registers
            wb_valid_r <= 1'b1;
            wb_num_r <= dest_r + cnt_r;
            wb_data_r <= mem_rdata;
            if (set_pend_r) begin
              // [RQ3] write ones back, lock kept
              set_pend_r <= 1'b0;
              mem_we_r <= 1'b1;
              mem_wdata_r <= `MCX_SET_ONES;
              state_r <= S_WRITE;
            end else if (more) begin
              // [RQ4] next word
              cnt_r <= cnt_r + 8'h01;
              mem_addr_r <= mem_addr_r + `MCX_WORD_STEP;
            end else begin
              mem_req_r <= 1'b0;
              mem_lock_r <= 1'b0;
              issue_ready_r <= 1'b1;
              state_r <= S_IDLE;
            end
          end
        end
        S_WRITE: begin
          if (mem_ack) begin
            mem_req_r <= 1'b0;
            if ((op_r == `MCX_OP_MULTI_WORD_WRITE) && more) begin
              // [RQ4] fetch next register
              cnt_r <= cnt_r + 8'h01;
              mem_addr_r <= mem_addr_r + `MCX_WORD_STEP;
              rf_rnum_r <= dest_r + cnt_r + 8'h01;
              state_r <= S_FETCH;
            end else begin
              mem_we_r <= 1'b0;
              mem_lock_r <= 1'b0;
              issue_ready_r <= 1'b1;
              state_r <= S_IDLE;
            end
          end
        end
        S_FETCH: begin
          // [RQ4] register data to channel
          mem_req_r <= 1'b1;
          mem_we_r <= 1'b1;
          mem_wdata_r <= rf_rdata;
          state_r <= S_WRITE;
        end
        S_SPRD: begin
          // [RQ22] word copy into register
          wb_valid_r <= 1'b1;
          wb_num_r <= dest_r;
          wb_data_r <= sprd_xlat_r ? xlat_rdata : sr_rdata;
          issue_ready_r <= 1'b1;
          state_r <= S_IDLE;
        end
        default: begin
          mem_req_r <= 1'b0;
          mem_lock_r <= 1'b0;
          issue_ready_r <= 1'b1;
          state_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule

//--- verification/mcx_mem_model.sv
`timescale 1ns/1ps
module mcx_mem_model (
  input wire core_clk,
  input wire rstn,
  input wire [1:0] lat,
  input wire mem_req_r,
  input wire mem_we_r,
  input wire [31:0] mem_addr_r,
  input wire [31:0] mem_wdata_r,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [logic [31:0]];
  logic [1:0] wait_cnt = 2'h0;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
  end
  function automatic logic [31:0] rd(input logic [31:0] addr);
    return mem.exists(addr) ? mem[addr] : addr * 32'h9E3779B1;
  endfunction
  // Answers after lat wait cycles; the data bus toggles whenever it carries nothing
  always @(posedge core_clk) begin
    mem_rdata <= ~mem_rdata;
    mem_ack <= 1'b0;
    if (!rstn) begin
      wait_cnt <= 2'h0;
    end else if (mem_req_r && !mem_ack) begin
      if (wait_cnt == lat) begin
        mem_ack <= 1'b1;
        wait_cnt <= 2'h0;
        if (mem_we_r)
          mem[mem_addr_r] = mem_wdata_r;
        else
          mem_rdata <= rd(mem_addr_r);
      end else begin
        wait_cnt <= wait_cnt + 2'h1;
      end
    end
  end
endmodule

//--- verification/mcx_exec_properties.sv
`timescale 1ns/1ps
`include "mcx_map.vh"
module mcx_exec_props (
  input wire core_clk,
  input wire rstn,
  input wire issue_valid,
  input wire issue_ready_r,
  input wire [4:0] issue_op,
  input wire [31:0] issue_a,
  input wire [31:0] issue_b,
  input wire issue_imm_sel,
  input wire [7:0] issue_imm8,
  input wire [15:0] issue_imm16,
  input wire [7:0] issue_dest,
  input wire [7:0] issue_sr_num,
  input wire [1:0] byte_pointer,
  input wire byte_order,
  input wire [29:0] pc_word,
  input wire supervisor,
  input wire wb_valid_r,
  input wire [7:0] wb_num_r,
  input wire [31:0] wb_data_r,
  input wire sr_we_r,
  input wire pc_load_r,
  input wire trap_r,
  input wire [7:0] trap_num_r,
  input wire mem_req_r,
  input wire mem_we_r,
  input wire mem_lock_r,
  input wire [31:0] mem_addr_r,
  input wire [31:0] mem_wdata_r,
  input wire mem_ack
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire take = issue_valid & issue_ready_r;
  wire [31:0] b_eff = issue_imm_sel ? {24'h0, issue_imm8} : issue_b;
  wire [7:0] a_byte = issue_a >> {byte_pointer, 3'h0};
  a_call_return: assert property (
    take && issue_op == `MCX_OP_CALL |=> wb_valid_r && wb_num_r == $past(issue_dest)
    && wb_data_r == {$past(pc_word), 2'h0} + `MCX_RET_OFS) else $error("call return address wrong");
  a_float_trap: assert property (
    take && issue_op == `MCX_OP_FLOAT |=> trap_r && trap_num_r == `MCX_TRAP_FP && !wb_valid_r)
    else $error("float op did not trap");
  a_upper_fill: assert property (
    take && issue_op == `MCX_OP_IMM16_UPPER_FILL |=> wb_valid_r
    && wb_data_r == {$past(issue_imm16), $past(issue_a[15:0])}) else $error("upper fill wrong");
  a_byte_extract: assert property (
    take && issue_op == `MCX_OP_BYTE_EXTRACTION && byte_order |=> wb_valid_r
    && wb_data_r == {$past(b_eff[31:8]), $past(a_byte)}) else $error("byte extraction wrong");
  a_lock_read: assert property (
    take && issue_op == `MCX_OP_LOCKED_READ |=> mem_req_r && mem_lock_r && !mem_we_r
    && mem_addr_r == $past(b_eff)) else $error("locked read request wrong");
  a_req_hold: assert property (
    mem_req_r && !mem_ack |=> mem_req_r && $stable(mem_addr_r) && $stable(mem_we_r) && $stable(mem_wdata_r)
    && $stable(mem_lock_r)) else $error("request changed before ack");
  a_delay_slot: assert property (
    pc_load_r |-> $past(take)) else $error("redirect without a delay instruction");
  a_lock_raise: assert property (
    take && (issue_op == `MCX_OP_LOCKED_WRITE || issue_op == `MCX_OP_READ_SET_ONES) |=> mem_req_r && mem_lock_r)
    else $error("lock not raised for locked access");
  a_priv_trap: assert property (
    take && issue_op == `MCX_OP_SPECIAL_REG_WRITE && !supervisor && issue_sr_num < `MCX_SR_USER_BASE
    |=> trap_r && trap_num_r == `MCX_TRAP_PROT && !sr_we_r) else $error("protected write not trapped");
endmodule
bind mcx_exec mcx_exec_props chk (.core_clk, .rstn, .issue_valid, .issue_ready_r, .issue_op, .issue_a,
  .issue_b, .issue_imm_sel, .issue_imm8, .issue_imm16, .issue_dest, .issue_sr_num, .byte_pointer, .byte_order,
  .pc_word, .supervisor, .wb_valid_r, .wb_num_r, .wb_data_r, .sr_we_r, .pc_load_r, .trap_r, .trap_num_r,
  .mem_req_r, .mem_we_r, .mem_lock_r, .mem_addr_r, .mem_wdata_r, .mem_ack);

//--- verification/tb.sv
`timescale 1ns/1ps
`include "mcx_map.vh"
module tb;
  logic core_clk = 1'b0, rstn = 1'b0, issue_valid = 1'b0, issue_imm_sel = 1'b0, byte_order = 1'b1, supervisor = 1'b0;
  logic [1:0] issue_tmode = 2'h0, byte_pointer = 2'h0, lat = 2'h0;
  logic [7:0] issue_imm8 = 8'h0, issue_dest = 8'h0, issue_a_num = 8'h0, issue_count = 8'h0, issue_sr_num = 8'h0;
  logic [4:0] issue_op = 5'h0, op;
  logic [15:0] issue_imm16 = 16'h0;
  logic [31:0] issue_a = 32'h0, issue_b = 32'h0, a, b, be, tg;
  logic [29:0] pc_word = 30'h0;
  logic tk;
  int k, fails = 0, total_checks = 0;
  logic [47:0] evq[$], expq[$];
  wire issue_ready_r, wb_valid_r, sr_we_r, xlat_we_r, pc_load_r, trap_r, mem_req_r, mem_we_r, mem_lock_r, mem_ack;
  wire [7:0] wb_num_r, rf_rnum_r, special_reg_target_r, trap_num_r;
  wire [31:0] wb_data_r, sr_wdata_r, xlat_wdata_r, pc_target_r, mem_addr_r, mem_wdata_r, mem_rdata;
  wire [5:0] xlat_idx_r;
  wire [31:0] rf_rdata = {4{rf_rnum_r}} ^ 32'h13579BDF;
  wire [31:0] sr_rdata = {special_reg_target_r, 24'hC0FFEE};
  wire [31:0] xlat_rdata = {26'h2AB3C4D, xlat_idx_r};
  mcx_exec #(.XLAT_AW(6)) DUT (.core_clk, .rstn, .issue_valid, .issue_op, .issue_a, .issue_b, .issue_imm_sel,
    .issue_imm8, .issue_imm16, .issue_tmode, .issue_dest, .issue_a_num, .issue_count, .issue_sr_num, .byte_pointer,
    .byte_order, .pc_word, .supervisor, .issue_ready_r, .wb_valid_r, .wb_num_r, .wb_data_r, .rf_rnum_r, .rf_rdata,
    .sr_we_r, .special_reg_target_r, .sr_wdata_r, .sr_rdata, .xlat_we_r, .xlat_idx_r, .xlat_wdata_r, .xlat_rdata,
    .pc_load_r, .pc_target_r, .trap_r, .trap_num_r, .mem_req_r, .mem_we_r, .mem_lock_r, .mem_addr_r, .mem_wdata_r,
    .mem_ack, .mem_rdata);
  mcx_mem_model mm (.core_clk, .rstn, .lat, .mem_req_r, .mem_we_r, .mem_addr_r, .mem_wdata_r, .mem_ack, .mem_rdata);
  always #25 core_clk = ~core_clk;
  // Pulses are read at the edge that ends them, before that edge's updates land
  always @(posedge core_clk) begin
    if (wb_valid_r) evq.push_back({8'h1, wb_num_r, wb_data_r});
    if (trap_r) evq.push_back({8'h2, trap_num_r, 32'h0});
    if (pc_load_r) evq.push_back({8'h3, 8'h0, pc_target_r});
    if (sr_we_r) evq.push_back({8'h4, special_reg_target_r, sr_wdata_r});
    if (xlat_we_r) evq.push_back({8'h5, 2'h0, xlat_idx_r, xlat_wdata_r});
  end
  task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  function automatic void ex(input logic [7:0] kind, input logic [7:0] num, input logic [31:0] d);
    expq.push_back({kind, num, d});
  endfunction
  function automatic logic [31:0] fexp(input logic [4:0] o, input logic [31:0] x, input logic [31:0] y,
      input logic [15:0] i16, input logic [1:0] bp, input logic bo);
    logic [31:0] r;
    int p, h;
    p = bo ? bp : 3 - bp;
    h = bo ? bp[1] : !bp[1];
    r = x;
    case (o)
      `MCX_OP_BYTE_EXTRACTION: r = {y[31:8], x[8*p +: 8]};
      `MCX_OP_HALFWORD_EXTRACTION: r = {y[31:16], x[16*h +: 16]};
      `MCX_OP_SIGNED_HALFWORD_EXTRACTION: r = {{16{x[16*h+15]}}, x[16*h +: 16]};
      `MCX_OP_BYTE_INSERTION: r[8*p +: 8] = y[7:0];
      `MCX_OP_HALFWORD_INSERTION: r[16*h +: 16] = y[15:0];
      `MCX_OP_IMM16_ZERO_EXT: r = {16'h0, i16};
      `MCX_OP_IMM16_UPPER_FILL: r = {i16, x[15:0]};
      default: r = {16'hFFFF, i16};
    endcase
    return r;
  endfunction
  // Entered at a falling edge; returns at the falling edge after the op was taken
  task automatic issue(input logic [4:0] o, input logic [31:0] x, input logic [31:0] y);
    int n = 0;
    issue_op = o;
    issue_a = x;
    issue_b = y;
    issue_valid = 1'b1;
    while (issue_ready_r !== 1'b1 && n < 50) begin
      @(negedge core_clk);
      fails += (++n == 50);
    end
    @(negedge core_clk);
  endtask
  task automatic flush;
    int n = 0;
    issue_valid = 1'b0;
    while ((issue_ready_r !== 1'b1 || mem_req_r !== 1'b0) && n < 200) begin
      @(negedge core_clk);
      fails += (++n == 200);
    end
    repeat (3) @(negedge core_clk);
    while (expq.size() > 0 || evq.size() > 0)
      chk("event", evq.size() ? evq.pop_front() : 48'h0, expq.size() ? expq.pop_front() : 48'h0);
  endtask
  initial begin
    #2000000;
    fails++;
    final_report();
  end
  initial begin
    void'($urandom(61688));
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    rstn = 1'b1;
    for (int i = 0; i < 48; i++) begin
      op = (i % 8 < 5) ? 5'h07 + i % 8 : 5'h0C + i % 8;
      a = (i < 8) ? 32'h80FF7F00 : $urandom;
      b = $urandom;
      issue_imm_sel = $urandom;
      issue_imm8 = $urandom;
      issue_imm16 = $urandom;
      issue_dest = $urandom;
      byte_order = (i < 16) ? i / 8 : $urandom;
      byte_pointer = $urandom;
      if (op == 5'h08 || op == 5'h09 || op == 5'h0B)
        byte_pointer[0] = 1'b0;
      be = issue_imm_sel ? {24'h0, issue_imm8} : b;
      ex(8'h1, issue_dest, fexp(op, a, be, issue_imm16, byte_pointer, byte_order));
      issue(op, a, b);
    end
    flush();
    for (int i = 0; i < 28; i++) begin
      op = (i % 7 < 5) ? 5'h0C + i % 7 : (i % 7 == 5 ? `MCX_OP_FLOAT : 5'h1F);
      a = $urandom;
      b = $urandom;
      issue_imm_sel = $urandom;
      issue_imm16 = $urandom;
      issue_dest = $urandom;
      issue_sr_num = (i < 14) ? 8'h7F + i % 2 : $urandom;
      supervisor = (i < 14) ? 1'b0 : $urandom;
      be = issue_imm_sel ? {24'h0, issue_imm8} : b;
      if (op == `MCX_OP_FLOAT)
        ex(8'h2, `MCX_TRAP_FP, 32'h0);
      else if (op != 5'h1F && !supervisor && (op >= `MCX_OP_XLAT_ENTRY_READ || issue_sr_num < `MCX_SR_USER_BASE))
        ex(8'h2, `MCX_TRAP_PROT, 32'h0);
      else case (op)
        `MCX_OP_SPECIAL_REG_READ: ex(8'h1, issue_dest, {issue_sr_num, 24'hC0FFEE});
        `MCX_OP_SPECIAL_REG_WRITE: ex(8'h4, issue_sr_num, be);
        `MCX_OP_SPECIAL_REG_WRITE_IMM: ex(8'h4, issue_sr_num, {16'h0, issue_imm16});
        `MCX_OP_XLAT_ENTRY_READ: ex(8'h1, issue_dest, {26'h2AB3C4D, a[5:0]});
        `MCX_OP_XLAT_ENTRY_WRITE: ex(8'h5, {2'h0, a[5:0]}, be);
        default: ;
      endcase
      issue(op, a, b);
    end
    flush();
    for (int i = 0; i < 30; i++) begin
      op = 5'h15 + i % 5;
      a = (i < 10) ? {i[0], 31'h0} : $urandom;
      b = $urandom;
      issue_imm_sel = 1'b0;
      issue_tmode = i % 3;
      issue_imm16 = $urandom;
      issue_dest = $urandom;
      issue_a_num = $urandom;
      pc_word = $urandom;
      tk = (op < `MCX_OP_BRANCH_IF_TRUE) || (a[31] == (op == `MCX_OP_BRANCH_IF_TRUE));
      tg = (issue_tmode == 2'h2) ? b : (issue_tmode == 2'h1) ?
        {pc_word, 2'h0} + {{14{issue_imm16[15]}}, issue_imm16, 2'h0} : {14'h0, issue_imm16, 2'h0};
      if (op == `MCX_OP_CALL)
        ex(8'h1, issue_dest, {pc_word, 2'h0} + `MCX_RET_OFS);
      if (op == `MCX_OP_BRANCH_FALSE_DECREMENT)
        ex(8'h1, issue_a_num, a - `MCX_DEC_ONE);
      issue(op, a, b);
      issue_imm16 = $urandom;
      issue_dest = $urandom;
      ex(8'h1, issue_dest, {16'h0, issue_imm16});
      if (tk)
        ex(8'h3, 8'h0, tg);
      issue(`MCX_OP_IMM16_ZERO_EXT, a, b);
    end
    flush();
    for (int i = 0; i < 21; i++) begin
      op = i % 7;
      lat = $urandom;
      a = $urandom;
      b = $urandom & 32'hFFFFFFFC;
      issue_imm_sel = (i % 3 == 0);
      issue_imm8 = $urandom & 8'hFC;
      issue_count = i % 3;
      issue_dest = $urandom % 200;
      be = issue_imm_sel ? {24'h0, issue_imm8} : b;
      if (op < `MCX_OP_MULTI_WORD_READ)
        ex(8'h1, issue_dest, mm.rd(be));
      if (op == `MCX_OP_MULTI_WORD_READ)
        for (k = 0; k <= issue_count; k++) ex(8'h1, issue_dest + k, mm.rd(be + 4 * k));
      issue(op, a, b);
      flush();
      if (op == `MCX_OP_STORE || op == `MCX_OP_LOCKED_WRITE)
        chk("stored word", mm.rd(be), a);
      if (op == `MCX_OP_READ_SET_ONES)
        chk("set word", mm.rd(be), `MCX_SET_ONES);
      if (op == `MCX_OP_MULTI_WORD_WRITE)
        for (k = 0; k <= issue_count; k++) chk("multi word", mm.rd(be + 4 * k), rf_f(issue_dest + k));
    end
    final_report();
  end
  function automatic logic [31:0] rf_f(input logic [7:0] n);
    return {4{n}} ^ 32'h13579BDF;
  endfunction
endmodule
